// >>> logic/sclg_pkg.sv
// Package for the step counter latch and gate block: register map and field layout
package sclg_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] FEAT_ADDR    = 12'h004;
  localparam logic [11:0] STAT_ADDR    = 12'h008;
  localparam logic [11:0] LATCH_ADDR   = 12'h00c;
  localparam logic [11:0] COUNT_ADDR   = 12'h010;
  localparam logic [11:0] IRQ_ST_ADDR  = 12'h014;
  localparam logic [11:0] IRQ_MSK_ADDR = 12'h018;
  // Control word bit positions
  localparam int ZERO_EN_BIT = 0;
  localparam int IN1_EN_BIT  = 1;
  localparam int IN2_EN_BIT  = 2;
  localparam int RISE_EN_BIT = 3;
  localparam int FALL_EN_BIT = 4;
  localparam int CTRL_W      = 5;
  // Feature register bit positions
  localparam int LOW_INH_BIT  = 12;
  localparam int HIGH_INH_BIT = 13;
  // Status word bit position
  localparam int INHIBIT_BIT = 7;
  // Interrupt status bits: capture event, inhibit entered
  localparam int IRQ_CAP_BIT = 0;
  localparam int IRQ_INH_BIT = 1;
  localparam int IRQ_W       = 2;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [1:0]        FEAT_RST = 2'h0;
  localparam logic [31:0]       WORD_RST = 32'h0000_0000;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
endpackage : sclg_pkg

// >>> logic/sclg_top.sv
// Step counter latch/gate block with AHB-Lite register slave
//
// Overview of operation
// - Input one rising edge latches counter
// - Input two rising edge latches counter
// - Zero mark rising edge latches counter
// - Gate rising edge latches counter
// - Gate falling edge latches counter
// - Low-level feature: gate low stops counting
// - High-level feature: gate high stops counting
// - Inhibited status shown while gate disables
`timescale 1ns/100ps
module sclg_top #(
  parameter int CNT_W = 32
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             count_step_i,
  input  wire logic             count_down_i,
  input  wire logic             zero_mark_i,
  input  wire logic             input_one_i,
  input  wire logic             input_two_i,
  input  wire logic             latch_gate_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  output logic                  counter_inhibited_flag_o,
  output logic                  irq_o
);

  typedef struct packed {
    logic [3:0]                 sync_q;     // Zero, in1, in2, gate samples
    logic [3:0]                 prev_q;     // Previous samples for edges
    logic [CNT_W-1:0]           count;
    logic [CNT_W-1:0]           latch_val;
    logic [sclg_pkg::CTRL_W-1:0] ctrl;
    logic                       gate_low_inhibit_feature;
    logic                       gate_high_inhibit_feature;
    logic                       inhibited;
    logic [sclg_pkg::IRQ_W-1:0] irq_status;
    logic [sclg_pkg::IRQ_W-1:0] irq_mask;
    logic                       irq;
    logic                       wr_pend;
    logic [11:0]                wr_addr;
    logic [31:0]                rdata;
  } sclg_state_t;

  sclg_state_t st;
  sclg_state_t next_st;

  // Read mux for one register word
  function automatic logic [31:0] sclg_read(input sclg_state_t s, input logic [11:0] a);
    logic [31:0] d;
    d = sclg_pkg::WORD_RST;
    if (a == sclg_pkg::CTRL_ADDR) begin
      d[sclg_pkg::CTRL_W-1:0] = s.ctrl;
    end else if (a == sclg_pkg::FEAT_ADDR) begin
      d[sclg_pkg::LOW_INH_BIT]  = s.gate_low_inhibit_feature;
      d[sclg_pkg::HIGH_INH_BIT] = s.gate_high_inhibit_feature;
    end else if (a == sclg_pkg::STAT_ADDR) begin
      d[sclg_pkg::INHIBIT_BIT] = s.inhibited;
    end else if (a == sclg_pkg::LATCH_ADDR) begin
      d[CNT_W-1:0] = s.latch_val;
    end else if (a == sclg_pkg::COUNT_ADDR) begin
      d[CNT_W-1:0] = s.count;
    end else if (a == sclg_pkg::IRQ_ST_ADDR) begin
      d[sclg_pkg::IRQ_W-1:0] = s.irq_status;
    end else if (a == sclg_pkg::IRQ_MSK_ADDR) begin
      d[sclg_pkg::IRQ_W-1:0] = s.irq_mask;
    end
    return d;
  endfunction : sclg_read

  // Whole next-state computation
  always_comb begin
    logic [3:0]                 rise;
    logic [3:0]                 fall;
    logic                       capture;
    logic                       inh;
    logic                       addr_ok;
    logic [sclg_pkg::IRQ_W-1:0] ev;
    rise    = '0;
    fall    = '0;
    capture = 1'b0;
    inh     = 1'b0;
    addr_ok = 1'b0;
    ev      = '0;
    next_st = st;

    // Pins are registered once; edges come from two registered samples
    next_st.sync_q = {zero_mark_i, input_one_i, input_two_i, latch_gate_i};
    next_st.prev_q = st.sync_q;
    rise = st.sync_q & ~st.prev_q;
    fall = ~st.sync_q & st.prev_q;

    // Gate level inhibit, bit 0 of sync_q is the gate
    inh = (st.gate_low_inhibit_feature & ~st.sync_q[0])
        | (st.gate_high_inhibit_feature & st.sync_q[0]);
    next_st.inhibited = inh;

    // Counter steps only while not inhibited
    if (count_step_i && !inh) begin
      next_st.count = count_down_i ? st.count - 1'b1 : st.count + 1'b1;
    end

    // Captures; all share one latch, so simultaneous edges store one value
    capture = (st.ctrl[sclg_pkg::ZERO_EN_BIT] & rise[3])
            | (st.ctrl[sclg_pkg::IN1_EN_BIT]  & rise[2])
            | (st.ctrl[sclg_pkg::IN2_EN_BIT]  & rise[1])
            | (st.ctrl[sclg_pkg::RISE_EN_BIT] & rise[0])
            | (st.ctrl[sclg_pkg::FALL_EN_BIT] & fall[0]);
    if (capture) begin
      next_st.latch_val = st.count;
    end

    // Write data phase; hwdata valid now
    if (st.wr_pend) begin
      next_st.wr_pend = 1'b0;
      if (st.wr_addr == sclg_pkg::CTRL_ADDR) begin
        next_st.ctrl = hwdata_i[sclg_pkg::CTRL_W-1:0];
      end else if (st.wr_addr == sclg_pkg::FEAT_ADDR) begin
        next_st.gate_low_inhibit_feature  = hwdata_i[sclg_pkg::LOW_INH_BIT];
        next_st.gate_high_inhibit_feature = hwdata_i[sclg_pkg::HIGH_INH_BIT];
      end else if (st.wr_addr == sclg_pkg::IRQ_ST_ADDR) begin
        next_st.irq_status = st.irq_status & ~hwdata_i[sclg_pkg::IRQ_W-1:0];
      end else if (st.wr_addr == sclg_pkg::IRQ_MSK_ADDR) begin
        next_st.irq_mask = hwdata_i[sclg_pkg::IRQ_W-1:0];
      end
    end

    // Events set after the clear so a same-cycle event wins
    ev[sclg_pkg::IRQ_CAP_BIT] = capture;
    ev[sclg_pkg::IRQ_INH_BIT] = inh & ~st.inhibited;
    next_st.irq_status = next_st.irq_status | ev;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // Address phase: zero wait states, read data registered for next cycle
    addr_ok = hsel_i && hready_i && (htrans_i == sclg_pkg::HTRANS_NONSEQ);
    if (addr_ok && hwrite_i) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_addr = haddr_i[11:0];
    end
    if (addr_ok && !hwrite_i) begin
      next_st.rdata = sclg_read(st, haddr_i[11:0]);
    end

    if (reset_i) begin
      next_st = '0;
      next_st.ctrl = sclg_pkg::CTRL_RST;
      next_st.gate_low_inhibit_feature  = sclg_pkg::FEAT_RST[0];
      next_st.gate_high_inhibit_feature = sclg_pkg::FEAT_RST[1];
    end
  end

  // Single state register
  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  // Outputs straight from flip-flops or tied constant; the slave never stalls
  assign hrdata_o                 = st.rdata;
  assign hreadyout_o              = 1'b1;
  assign hresp_o                  = sclg_pkg::HRESP_OKAY;
  assign counter_inhibited_flag_o = st.inhibited;
  assign irq_o                    = st.irq;

endmodule : sclg_top

// >>> tb/sclg_top_props.sv
// Port checker for the latch and gate block
`timescale 1ns/100ps
module sclg_top_props (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        latch_gate_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        counter_inhibited_flag_o,
  input wire logic        irq_o
);
  logic rq, wq, was_rst;
  // Accepted address phases; one quiet edge after reset masks stale samples
  assign rq = hsel_i && hready_i && htrans_i == sclg_pkg::HTRANS_NONSEQ && !hwrite_i;
  assign wq = hsel_i && hready_i && htrans_i == sclg_pkg::HTRANS_NONSEQ && hwrite_i;
  always_ff @(posedge clock_i) was_rst <= reset_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i || was_rst);
  a_flag_cause: assert property ($changed(counter_inhibited_flag_o) |->
    $past(latch_gate_i, 2) != $past(latch_gate_i, 3) || $past(wq, 2) || $past(wq, 3))
    else $error("inhibit flag moved without cause");
  a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(rq))
    else $error("read data moved without a read");
  a_ready_const: assert property (hreadyout_o) else $error("wait state");
  a_resp_okay: assert property (hresp_o == sclg_pkg::HRESP_OKAY) else $error("bad response");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wq, 2) || $past(wq, 3))
    else $error("interrupt dropped without a write");
  a_reset_flag: assert property (disable iff (1'b0) reset_i |=> !counter_inhibited_flag_o)
    else $error("flag set after reset");
  a_reset_irq: assert property (disable iff (1'b0) reset_i |=> !irq_o) else $error("irq after reset");
  a_reset_rdata: assert property (disable iff (1'b0) reset_i |=> hrdata_o == 32'h0)
    else $error("read data after reset");
endmodule : sclg_top_props
bind sclg_top sclg_top_props u_props (.clock_i, .reset_i, .latch_gate_i, .hsel_i, .htrans_i,
  .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .counter_inhibited_flag_o, .irq_o);

// >>> tb/sclg_ctl.sv
// Controller model: single word AHB-Lite master
`timescale 1ns/100ps
module sclg_ctl (
  input  wire logic        clock_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [31:0] hwdata_o
);
  logic timed_out = 1'b0;
  initial {haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
  // Bounded wait for hready; the caller sees x if it never comes
  task automatic hold();
    int n;
    n = 0;
    do @(posedge clock_i); while (!hready_i && ++n < 8);
    if (!hready_i) timed_out = 1'b1; // Bound used up: bench reports it
  endtask : hold
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr_o <= {20'h0, a};
    htrans_o <= sclg_pkg::HTRANS_NONSEQ;
    hwrite_o <= w;
    hold();
    htrans_o <= 2'h0;
    hwdata_o <= d;
    hold();
    r = hready_i ? hrdata_i : 'x;
  endtask : xfer
endmodule : sclg_ctl

// >>> tb/sclg_top_tb.sv
// Bench: captures, inhibit and interrupts through the register bus
`timescale 1ns/100ps
module sclg_top_tb;
  logic        clk = 1'b0, rst = 1'b1, stp = 1'b0, dn = 1'b0;
  logic [3:0]  pin = 4'h0;
  logic [31:0] haddr, hwdata, hrdata, q, cnt, e, seed;
  logic [1:0]  htrans;
  logic        hwrite, hrdy, flag, irq;
  int          failures = 0, checks_done = 0, k, p;
  initial forever #12.5 clk = ~clk;
  sclg_top dut (.clock_i(clk), .reset_i(rst), .count_step_i(stp), .count_down_i(dn),
    .zero_mark_i(pin[0]), .input_one_i(pin[1]), .input_two_i(pin[2]), .latch_gate_i(pin[3]),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
    .counter_inhibited_flag_o(flag), .irq_o(irq));
  sclg_ctl m (.clock_i(clk), .hready_i(hrdy), .hrdata_i(hrdata), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
  // A bus wait that ran out counts as a mismatch and ends the run
  task automatic tmo();
    if (m.timed_out) begin
      failures++;
      stop_test();
    end
  endtask : tmo
  task automatic rd(input logic [11:0] a, input logic [31:0] x); m.xfer(0, a, 0, q); chk(q, x);
    tmo();
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d); m.xfer(1, a, d, q); tmo();
  endtask : wr
  // Flag and irq looked at mid-cycle, where they have settled
  task automatic probe(input logic [1:0] x); @(negedge clk); chk({flag, irq}, x); @(posedge clk);
  endtask : probe
  // Steps counted by the bench model only while not inhibited
  task automatic steps(input int n, input logic d, input logic live);
    dn <= d;
    stp <= 1'b1;
    cyc(n);
    stp <= 1'b0;
    if (live) cnt = d ? cnt - n : cnt + n;
  endtask : steps
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    seed = 32'h0001_5e5d;
    cnt = 32'h0;
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    rd(sclg_pkg::CTRL_ADDR, 0);
    rd(sclg_pkg::LATCH_ADDR, 0);
    rd(12'h01c, 0);
    // Every source alone; steps between its two edges tell rise from fall
    for (int i = 0; i < 5; i++) begin
      q = rnd();
      k = int'(q[2:0]) + 1;
      p = i > 3 ? 3 : i;
      wr(sclg_pkg::CTRL_ADDR, 32'h1 << i);
      e = cnt;
      pin[p] <= 1'b1;
      cyc(3);
      steps(k, q[3], 1'b1);
      pin[p] <= 1'b0;
      cyc(3);
      rd(sclg_pkg::LATCH_ADDR, i == 4 ? cnt : e);
    end
    e = cnt;
    wr(sclg_pkg::CTRL_ADDR, 0);
    steps(5, 1'b0, 1'b1);
    pin <= 4'hf;
    cyc(3);
    pin <= 4'h0;
    cyc(3);
    rd(sclg_pkg::LATCH_ADDR, e);
    // Low then high inhibit level
    for (int b = 0; b < 2; b++) begin
      wr(sclg_pkg::FEAT_ADDR, 32'h1 << (sclg_pkg::LOW_INH_BIT + b));
      pin[3] <= 1'(b);
      cyc(3);
      probe(2'h2);
      rd(sclg_pkg::STAT_ADDR, 32'h1 << sclg_pkg::INHIBIT_BIT);
      steps(4, 1'b0, 1'b0);
      rd(sclg_pkg::COUNT_ADDR, cnt);
      pin[3] <= 1'(!b);
      cyc(3);
      probe(2'h0);
      steps(3, 1'b0, 1'b1);
      rd(sclg_pkg::COUNT_ADDR, cnt);
    end
    rd(sclg_pkg::IRQ_ST_ADDR, 32'h3);
    wr(sclg_pkg::IRQ_MSK_ADDR, 32'h1);
    probe(2'h1);
    wr(sclg_pkg::IRQ_ST_ADDR, 32'h3);
    probe(2'h0);
    rd(sclg_pkg::IRQ_ST_ADDR, 0);
    stop_test();
  end
endmodule : sclg_top_tb
